// >>> include/psd_pkg.sv
// Constants and types shared by the synthesizer divider core.
// Assumes a single crystal-rate clock; register offsets are whole-register (24-bit word) addresses on a plain port.
package psd_pkg;
  localparam int PSD_ADDR_W = 8;
  localparam int PSD_DATA_W = 24;
  localparam int PSD_RATIO_W = 14;
  localparam logic [7:0] PSD_ADDR_CFG = 8'hd0;
  localparam logic [7:0] PSD_ADDR_STAT = 8'hd1;
  localparam logic [7:0] PSD_ADDR_CTRL = 8'hd2;
  // Layout of the first input register
  localparam int PSD_DIV_LSB = 0;
  localparam int PSD_SWAL_W = 4;
  localparam int PSD_MAIN_W = 12;
  localparam int PSD_REF_LSB = 16;
  localparam int PSD_MODE_BIT = 20;
  localparam int PSD_BAND_BIT = 21;
  localparam int PSD_XTAL_BIT = 22;
  localparam int PSD_RDSEL_BIT = 23;
  // Layout of the second input register and the lock status word
  localparam int PSD_UNLK_CLR_BIT = 0;
  localparam int PSD_TEST_BIT = 1;
  localparam int PSD_ST_UNLOCK_BIT = 0;
  localparam int PSD_ST_TEN_BIT = 1;
  localparam logic [23:0] PSD_CFG_RST = 24'h000000;
  localparam logic [23:0] PSD_CTRL_RST = 24'h000000;
  // Dual-modulus prescaler: last count of the divide-by-16 and divide-by-17 cycles
  localparam logic [4:0] PSD_PRESC_LAST_LO = 5'h0f;
  localparam logic [4:0] PSD_PRESC_LAST_HI = 5'h10;
  // Crystal cycles per reference period; zero marks a rate that cannot be made
  localparam logic [13:0] PSD_RATIO_XTAL_LO [16] = '{
    14'h2328, 14'h1194, 14'h0708, 14'h05dc, 14'h05a0, 14'h0480, 14'h0384, 14'h02d0,
    14'h0240, 14'h01f4, 14'h01c2, 14'h0168, 14'h00b4, 14'h005a, 14'h002d, 14'h0000};
  localparam logic [13:0] PSD_RATIO_XTAL_HI [16] = '{
    14'h3840, 14'h1c20, 14'h0b40, 14'h0960, 14'h0900, 14'h0000, 14'h05a0, 14'h0480,
    14'h0000, 14'h0320, 14'h02d0, 14'h0240, 14'h0120, 14'h0090, 14'h0048, 14'h0000};
  typedef enum logic [1:0] {
    direct_low_mode,
    swallow_mid_mode,
    swallow_vhf_mode,
    halved_vhf_mode
  } psd_div_mode_e;
endpackage

// >>> rtl/psd_core.sv
// Digital core of a tuning synthesizer: programmable divider, reference divider,
// phase comparator and unlock detection, with settings reached over a plain register port.
// Assumes sys_clk is the crystal clock; band inputs and the latch strobe arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none

module psd_core (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [psd_pkg::PSD_ADDR_W-1:0] reg_addr,
  input wire logic [psd_pkg::PSD_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [psd_pkg::PSD_DATA_W-1:0] reg_rdata,
  input wire logic latch_strobe,
  input wire logic low_band_input,
  input wire logic high_band_input,
  output logic phase_out_a,
  output logic phase_out_a_oe,
  output logic phase_out_b,
  output logic phase_out_b_oe
);
  import psd_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] latch_sync_q, lo_sync_q, hi_sync_q;
  logic latch_prev_q, lo_prev_q, hi_prev_q;
  logic latch_fall, lo_rise, hi_rise;
  logic [23:0] cfg_sh_q, cfg_q, ctrl_sh_q;
  logic ctrl_pend_q, clr_evt;
  psd_div_mode_e div_mode;
  logic in_edge, stage_edge, halve_q, presc_tick, main_step, div_tick;
  logic [4:0] presc_cnt_q, presc_last;
  logic [3:0] swal_cnt_q;
  logic [11:0] main_cnt_q, main_load;
  logic [13:0] ref_cnt_q, ref_ratio;
  logic ref_tick;
  logic up_q, dn_q, up_d, dn_d, err;
  logic unlock_q, ten_q;
  logic [23:0] rd_val;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pins pass two flops; only the second is looked at by edge detectors
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_sync_q <= 2'h0;
      lo_sync_q <= 2'h0;
      hi_sync_q <= 2'h0;
      latch_prev_q <= 1'b0;
      lo_prev_q <= 1'b0;
      hi_prev_q <= 1'b0;
    end else begin
      latch_sync_q <= {latch_sync_q[0], latch_strobe};
      lo_sync_q <= {lo_sync_q[0], low_band_input};
      hi_sync_q <= {hi_sync_q[0], high_band_input};
      latch_prev_q <= latch_sync_q[1];
      lo_prev_q <= lo_sync_q[1];
      hi_prev_q <= hi_sync_q[1];
    end
  end
  assign latch_fall = latch_prev_q & ~latch_sync_q[1];
  assign lo_rise = lo_sync_q[1] & ~lo_prev_q;
  assign hi_rise = hi_sync_q[1] & ~hi_prev_q;

  // Writes land in shadows; nothing changes behaviour until the strobe falls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_sh_q <= PSD_CFG_RST;
      ctrl_sh_q <= PSD_CTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == PSD_ADDR_CFG) begin
        cfg_sh_q <= reg_wdata;
      end
      if (reg_addr == PSD_ADDR_CTRL) begin
        ctrl_sh_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= PSD_CFG_RST;
    end else if (latch_fall) begin
      cfg_q <= cfg_sh_q;
    end
  end

  // A write during the strobe edge is kept for the next transfer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_pend_q <= 1'b0;
    end else if (reg_wr && reg_addr == PSD_ADDR_CTRL) begin
      ctrl_pend_q <= 1'b1;
    end else if (latch_fall) begin
      ctrl_pend_q <= 1'b0;
    end
  end
  assign clr_evt = latch_fall & ctrl_pend_q & ctrl_sh_q[PSD_UNLK_CLR_BIT];

  always_comb begin
    unique case ({cfg_q[PSD_BAND_BIT], cfg_q[PSD_MODE_BIT]})
      2'b00: div_mode = direct_low_mode;
      2'b01: div_mode = swallow_mid_mode;
      2'b10: div_mode = swallow_vhf_mode;
      2'b11: div_mode = halved_vhf_mode;
    endcase
  end

  assign in_edge = cfg_q[PSD_BAND_BIT] ? hi_rise : lo_rise;

  // Divide-by-2 front stage passes every second edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halve_q <= 1'b0;
    end else if (div_mode != halved_vhf_mode) begin
      halve_q <= 1'b0;
    end else if (in_edge) begin
      halve_q <= ~halve_q;
    end
  end
  assign stage_edge = in_edge & ((div_mode != halved_vhf_mode) | halve_q);

  // Prescaler divides by 17 while swallow count remains, else by 16
  assign presc_last = (swal_cnt_q != 4'h0) ? PSD_PRESC_LAST_HI : PSD_PRESC_LAST_LO;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt_q <= 5'h00;
    end else if (div_mode == direct_low_mode) begin
      presc_cnt_q <= 5'h00;
    end else if (stage_edge) begin
      presc_cnt_q <= (presc_cnt_q >= presc_last) ? 5'h00 : presc_cnt_q + 5'h01;
    end
  end
  assign presc_tick = stage_edge & (presc_cnt_q >= presc_last);

  // Direct mode feeds the main counter straight from the input
  assign main_step = (div_mode == direct_low_mode) ? stage_edge : presc_tick;
  assign main_load = (div_mode == direct_low_mode) ? cfg_q[15:4] : cfg_q[15:4];
  assign div_tick = main_step & (main_cnt_q <= 12'h001);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_cnt_q <= 12'h000;
    end else if (main_step) begin
      main_cnt_q <= div_tick ? main_load : main_cnt_q - 12'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      swal_cnt_q <= 4'h0;
    end else if (div_mode == direct_low_mode) begin
      swal_cnt_q <= 4'h0;
    end else if (div_tick) begin
      swal_cnt_q <= cfg_q[PSD_DIV_LSB +: PSD_SWAL_W];
    end else if (presc_tick && swal_cnt_q != 4'h0) begin
      swal_cnt_q <= swal_cnt_q - 4'h1;
    end
  end

  // Reference divider; unassigned rates give no reference edges at all
  assign ref_ratio = cfg_q[PSD_XTAL_BIT] ? PSD_RATIO_XTAL_HI[cfg_q[PSD_REF_LSB +: 4]]
                                          : PSD_RATIO_XTAL_LO[cfg_q[PSD_REF_LSB +: 4]];
  assign ref_tick = (ref_cnt_q == 14'h0000) & (ref_ratio != 14'h0000);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_q <= 14'h0000;
    end else if (ref_tick) begin
      ref_cnt_q <= ref_ratio - 14'h0001;
    end else if (ref_cnt_q != 14'h0000) begin
      ref_cnt_q <= ref_cnt_q - 14'h0001;
    end
  end

  // Phase-frequency detector: up means divider lags, dn means it leads
  always_comb begin
    up_d = up_q | ref_tick;
    dn_d = dn_q | div_tick;
    if (up_d && dn_d) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_d;
      dn_q <= dn_d;
    end
  end

  // Both pins carry the same result so each loop filter sees it unchanged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_out_a <= 1'b0;
      phase_out_a_oe <= 1'b0;
      phase_out_b <= 1'b0;
      phase_out_b_oe <= 1'b0;
    end else begin
      phase_out_a <= up_q;
      phase_out_a_oe <= up_q ^ dn_q;
      phase_out_b <= up_q;
      phase_out_b_oe <= up_q ^ dn_q;
    end
  end

  // A second edge on either side before the other answers is a missed period
  assign err = (ref_tick & up_q) | (div_tick & dn_q);

  // Set wins over clear so an error in the clearing cycle is not lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= 1'b0;
    end else if (err) begin
      unlock_q <= 1'b1;
    end else if (clr_evt) begin
      unlock_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ten_q <= 1'b0;
    end else if (ref_tick) begin
      ten_q <= 1'b1;
    end else if (clr_evt) begin
      ten_q <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 24'h000000;
    unique case (reg_addr)
      PSD_ADDR_CFG: rd_val = cfg_q;
      PSD_ADDR_STAT: begin
        if (cfg_q[PSD_RDSEL_BIT]) begin
          rd_val = cfg_q;
        end else begin
          rd_val[PSD_ST_UNLOCK_BIT] = unlock_q;
          rd_val[PSD_ST_TEN_BIT] = ten_q;
        end
      end
      PSD_ADDR_CTRL: rd_val = ctrl_sh_q;
      default: rd_val = 24'h000000;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 24'h000000;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_latch_apply;
    latch_fall ##1 1'b1;
  endsequence
  sequence s_halve_pair;
    in_edge && div_mode == halved_vhf_mode && !halve_q;
  endsequence

  a_xtal_por_low: assert property ($rose(rst_n) |-> !cfg_q[PSD_XTAL_BIT])
    else $error("crystal select not low after reset");
  a_latch_apply: assert property (latch_fall |-> s_latch_apply ##0 cfg_q == $past(cfg_sh_q))
    else $error("settings not applied at strobe fall");
  a_ref_reload: assert property (ref_tick |=> ref_cnt_q == $past(ref_ratio) - 14'h0001)
    else $error("reference divider reload wrong");
  a_ref_xtal_ratio: assert property (cfg_q[PSD_XTAL_BIT] && cfg_q[19:16] == 4'h5 |-> !ref_tick)
    else $error("unavailable rate produced reference edges");
  a_halve_skip: assert property (s_halve_pair |-> !stage_edge ##1 halve_q)
    else $error("divide-by-2 stage passed both edges");
  a_direct_load: assert property (div_tick && div_mode == direct_low_mode
                                  |=> main_cnt_q == $past(cfg_q[15:4]) && presc_cnt_q == 5'h00)
    else $error("direct reload wrong");
  a_swallow_load: assert property (div_tick && div_mode != direct_low_mode
                                   |=> swal_cnt_q == $past(cfg_q[3:0]))
    else $error("swallow counter reload wrong");
  a_unlock_set: assert property (err |=> unlock_q [*2] or (unlock_q ##1 $past(clr_evt)))
    else $error("error pulse did not set unlock");
  a_unlock_clear: assert property (clr_evt && !err |=> !unlock_q)
    else $error("unlock clear ignored");
  a_ten_cycle: assert property (clr_evt && !ref_tick |=> !ten_q)
    else $error("test enable not cleared");
  a_ten_hold: assert property (!ten_q && !ref_tick |=> !ten_q)
    else $error("test enable rose without reference tick");
  a_ten_set: assert property (ref_tick |=> ten_q)
    else $error("test enable not set at detection point");
  a_dual_out: assert property (phase_out_a == phase_out_b && phase_out_a_oe == phase_out_b_oe)
    else $error("phase outputs differ");
  a_lead_low: assert property (dn_q && !up_q |=> phase_out_a_oe && !phase_out_a)
    else $error("lead not driven low");
endmodule

`default_nettype wire

// >>> sim/psd_vco_model.sv
// Behavioural oscillator on the far side of the band inputs.
// Assumes the bench sets the half period in ns; both pins stand still while stopped.
`timescale 1ns/1ps
`default_nettype none
module psd_vco_model (
  input wire logic run,
  input wire logic use_high,
  input var int half_ns,
  output logic low_band_input,
  output logic high_band_input
);
  logic osc_q = 1'b0;
  // Offset start keeps edges clear of the sampling clock edge
  always begin
    if (run) begin
      #(half_ns);
      osc_q = ~osc_q;
    end else begin
      osc_q = 1'b0;
      @(posedge run);
      #3;
    end
  end
  // Only the selected band pin toggles; the other sits low
  assign low_band_input = osc_q & ~use_high;
  assign high_band_input = osc_q & use_high;
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the synthesizer core: register port tasks and lock scenarios.
// Assumes the register map of psd_pkg and the oscillator model on the band pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psd_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [PSD_ADDR_W-1:0] reg_addr = '0;
  logic [PSD_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic latch_strobe = 1'b1;
  logic [PSD_DATA_W-1:0] reg_rdata;
  logic low_band_input;
  logic high_band_input;
  logic phase_out_a;
  logic phase_out_a_oe;
  logic phase_out_b;
  logic phase_out_b_oe;
  logic vco_run = 1'b0;
  logic vco_high = 1'b0;
  int vco_half = 160;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int lead_seen = 0;
  logic [23:0] rdv;
  logic [3:0] rsel [4] = '{4'hf, 4'h5, 4'h8, 4'h5};
  logic xsel [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [1:0] rexp [4] = '{2'b00, 2'b00, 2'b00, 2'b11};
  logic mmd [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic mbd [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic mhi [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [15:0] mdiv [6] = '{16'h02d0, 16'h02df, 16'h0213, 16'h0213, 16'h0213, 16'h02d0};
  logic mexp [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  always #20 sys_clk = ~sys_clk;

  psd_core dut_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .latch_strobe(latch_strobe),
    .low_band_input(low_band_input),
    .high_band_input(high_band_input),
    .phase_out_a(phase_out_a),
    .phase_out_a_oe(phase_out_a_oe),
    .phase_out_b(phase_out_b),
    .phase_out_b_oe(phase_out_b_oe)
  );

  psd_vco_model vco_u (
    .run(vco_run),
    .use_high(vco_high),
    .half_ns(vco_half),
    .low_band_input(low_band_input),
    .high_band_input(high_band_input)
  );

  function automatic logic [23:0] cfgw(logic [15:0] dv, logic [3:0] rs, logic md, logic bd, logic xs, logic rb);
    cfgw = '0;
    cfgw[15:0] = dv;
    cfgw[PSD_REF_LSB +: 4] = rs;
    cfgw[PSD_MODE_BIT] = md;
    cfgw[PSD_BAND_BIT] = bd;
    cfgw[PSD_XTAL_BIT] = xs;
    cfgw[PSD_RDSEL_BIT] = rb;
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // Data stand for the cycle after the strobe; take them at its closing edge
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  // Strobe low long enough for the two-flop sampler and edge detect
  task automatic latch();
    repeat (2) @(posedge sys_clk);
    latch_strobe <= 1'b0;
    repeat (6) @(posedge sys_clk);
    latch_strobe <= 1'b1;
  endtask

  task automatic stat(input logic [1:0] exp);
    rd(PSD_ADDR_STAT, rdv);
    check(rdv, {22'h0, exp});
  endtask

  task automatic set_cfg(input logic [23:0] w);
    wr(PSD_ADDR_CFG, w);
    latch();
  endtask

  task automatic clr();
    wr(PSD_ADDR_CTRL, 24'h000001);
    latch();
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (8803) @(posedge sys_clk);
    // Reference counter starts empty: one tick right after reset, the next a low-crystal period later
    stat(2'b10);
    repeat (400) @(posedge sys_clk);
    stat(2'b11);
    check({20'h0, phase_out_a, phase_out_a_oe, phase_out_b, phase_out_b_oe}, 24'h00000f);
    rd(8'h7f, rdv);
    check(rdv, 24'h0);
    wr(PSD_ADDR_STAT, 24'hffffff);
    wr(PSD_ADDR_CFG, cfgw(16'h0050, 4'he, 1'b0, 1'b0, 1'b0, 1'b1));
    stat(2'b11);
    latch();
    rd(PSD_ADDR_STAT, rdv);
    check(rdv, cfgw(16'h0050, 4'he, 1'b0, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 4; i++) begin
      set_cfg(cfgw(16'h0050, rsel[i], 1'b0, 1'b0, xsel[i], 1'b0));
      clr();
      stat(2'b00);
      repeat (2500) @(posedge sys_clk);
      stat(rexp[i]);
    end
    vco_run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      vco_high <= mhi[i];
      set_cfg(cfgw(mdiv[i], 4'hb, mmd[i], mbd[i], 1'b0, 1'b0));
      // Old reference count may run out first; let the loop settle before clearing
      repeat (1200) @(posedge sys_clk);
      clr();
      // Wait several reference periods so the flag reflects the true state
      repeat (1200) @(posedge sys_clk);
      stat({1'b1, mexp[i]});
    end
    vco_high <= 1'b0;
    // Divider at 2.25 times the reference rate, so it leads
    set_cfg(cfgw(16'h0140, 4'hb, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (800) begin
      @(negedge sys_clk);
      if (phase_out_a_oe === 1'b1 && phase_out_a === 1'b0) begin
        lead_seen++;
      end
      check({22'h0, phase_out_a, phase_out_a_oe}, {22'h0, phase_out_b, phase_out_b_oe});
    end
    check({23'h0, lead_seen > 0}, 24'h000001);
    vco_run <= 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
